//--- core/acs_core.sv
// conversion sequencer: wishbone registers, channel routing and SAR control
//
// Function
// R1 - fourteen pins plus one internal, one routed
// R2 - full resolution gives twelve-bit result
// R3 - enable plus start bits begin conversion; the code also requires global enable written as one
// R4 - done sets end flag, stores result
// R5 - input connects only with global enable
// R6 - reference select: zero internal, one external
// R7 - resolution bit picks eight or twelve bits
// R8 - twelve or sixteen steps, four clocks each
// R9 - conversion time runs start to end flag
// R10 - three-bit divider: none, 2,4,8,16,32
// R11 - peripheral clock kept below 16 MHz
// R12 - software disables converter before sleep
// R13 - software waits 100 us after enable
// R14 - start self-clears; start clears end flag
// R15 - select value indexes input directly
// R16 - temperature sensor sits on channel fourteen
// R17 - enable bit powers converter on, off
// R18 - start during conversion is ignored
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module acs_core
  import acs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cmp_above,
  output logic             adc_power,
  output logic             ain_connect,
  output logic      [3:0]  ain_sel,
  output logic             temp_route,
  output logic             ref_ext_sel,
  output logic             sample_hold,
  output logic      [11:0] dac_code,
  output logic             irq
);

  // all state of the block
  typedef struct packed {
    logic         ack;     // bus answer
    logic [31:0]  rdat;    // read data
    logic         en;      // converter_enable
    logic         gen;     // global_input_enable
    logic         refx;    // high_reference_select
    logic         res;     // resolution_select, 1 = 12 bit
    logic [3:0]   sel;     // input_select
    logic [2:0]   div;     // conversion_clock_divider
    logic         busy;    // conversion in flight
    logic         eoc;     // end of conversion flag
    logic [11:0]  result;  // result_register
    logic         istat;   // sticky done event
    logic         imask;   // done event mask
    logic         irq;     // interrupt line
    acs_state_e_t st;      // sequencer state
    logic [1:0]   tk;      // period within a step
    logic [3:0]   cnt;     // sample step or bit index
    logic         l_res;   // resolution held for the conversion
    logic [3:0]   l_sel;   // channel held for the conversion
    logic [2:0]   l_div;   // divider held for the conversion
    logic [11:0]  dac;     // trial code
    logic         cmp_s1;  // comparator sync, first stage
    logic         cmp_s2;  // comparator sync, second stage
    logic         conn;    // analog switch closed
    logic [3:0]   rsel;    // channel driven to the mux
    logic         trt;     // temperature channel routed
    logic         smp;     // sampling switch closed
  } acs_st_t;

  acs_st_t     q;       // registered state
  acs_st_t     d;       // next state
  logic        acc;     // new bus request this cycle
  logic        wr;      // write request
  logic [7:0]  adr_w;   // word-aligned byte address
  logic        go;      // a write asks for a conversion
  logic        start;   // conversion accepted
  logic        tick;    // one conversion clock period
  logic [3:0]  msb;     // top bit for the held resolution

  // bus decode; ack is registered so each request is seen once
  assign acc   = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr    = acc & wb_we_i;
  assign adr_w = {wb_adr_i[7:2], 2'b00};

  // start needs start, global enable and power written as ones
  assign go = wr && (adr_w == ACS_CTRL_OFS) && wb_sel_i[0]
              && wb_dat_i[ACS_B_START] && wb_dat_i[ACS_B_GEN]
              && wb_dat_i[ACS_B_EN];  // R3
  // a request during a conversion is dropped
  assign start = go && !q.busy;  // R18
  assign msb   = q.l_res ? ACS_MSB_12 : ACS_MSB_8;  // R7

  // conversion clock from the held divider code
  acs_clkdiv u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (start),
    .div_sel  (q.l_div),
    .tick     (tick)
  );

  // next-state logic: bus, sequencer, outputs
  always_comb begin
    d = q;
    // comparator enters through two flip-flops
    d.cmp_s1 = cmp_above;
    d.cmp_s2 = q.cmp_s1;
    d.ack    = acc;
    d.rdat   = 32'h0000_0000;

    // register writes, honouring byte lanes
    if (wr) begin
      case (adr_w)
        ACS_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            d.en   = wb_dat_i[ACS_B_EN];   // R17
            d.gen  = wb_dat_i[ACS_B_GEN];
            d.refx = wb_dat_i[ACS_B_REF];  // R6
            d.res  = wb_dat_i[ACS_B_RES];  // R7
          end
          if (wb_sel_i[1]) begin
            d.sel = wb_dat_i[ACS_B_SEL +: 4];  // R15
          end
          if (wb_sel_i[2]) begin
            d.div = wb_dat_i[ACS_B_DIV +: 3];  // R10
          end
        end
        ACS_ISTAT_OFS: begin
          // write one to clear
          if (wb_sel_i[0] && wb_dat_i[0]) begin
            d.istat = 1'b0;
          end
        end
        ACS_IMASK_OFS: begin
          if (wb_sel_i[0]) begin
            d.imask = wb_dat_i[0];
          end
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end

    // register reads; unmapped words read zero
    if (acc && !wb_we_i) begin
      case (adr_w)
        ACS_CTRL_OFS: begin
          d.rdat[ACS_B_EN]       = q.en;
          d.rdat[ACS_B_GEN]      = q.gen;
          d.rdat[ACS_B_START]    = q.busy;  // R14
          d.rdat[ACS_B_REF]      = q.refx;
          d.rdat[ACS_B_RES]      = q.res;
          d.rdat[ACS_B_SEL +: 4] = q.sel;
          d.rdat[ACS_B_DIV +: 3] = q.div;
        end
        ACS_STAT_OFS: begin
          d.rdat[ACS_B_EOC]  = q.eoc;
          d.rdat[ACS_B_BUSY] = q.busy;
        end
        ACS_DATA_OFS: begin
          d.rdat[11:0] = q.result;  // R2
        end
        ACS_ISTAT_OFS: begin
          d.rdat[0] = q.istat;
        end
        ACS_IMASK_OFS: begin
          d.rdat[0] = q.imask;
        end
        default: begin
          d.rdat = 32'h0000_0000;
        end
      endcase
    end

    // successive approximation sequencer
    case (q.st)
      ACS_IDLE: begin
        if (start) begin
          d.st    = ACS_SAMPLE;  // R3
          d.busy  = 1'b1;
          d.eoc   = 1'b0;        // R14
          d.l_res = wb_dat_i[ACS_B_RES];
          d.l_sel = wb_sel_i[1] ? wb_dat_i[ACS_B_SEL +: 4] : q.sel;
          d.l_div = wb_sel_i[2] ? wb_dat_i[ACS_B_DIV +: 3] : q.div;
          d.tk    = 2'h0;
          d.cnt   = 4'h0;
          d.dac   = 12'h000;
        end
      end
      ACS_SAMPLE: begin
        // four steps of sampling before the first bit
        if (tick) begin
          d.tk = q.tk + 2'h1;
          if (q.tk == ACS_TICK_LAST) begin  // R8
            if (q.cnt == ACS_SAMP_LAST) begin
              d.st       = ACS_BITS;
              d.cnt      = msb;
              d.dac[msb] = 1'b1;
            end else begin
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
      end
      ACS_BITS: begin
        // one result bit per step, msb first
        if (tick) begin
          d.tk = q.tk + 2'h1;
          if (q.tk == ACS_TICK_LAST) begin  // R8
            if (!q.cmp_s2) begin
              d.dac[q.cnt] = 1'b0;
            end
            if (q.cnt == 4'h0) begin
              d.st     = ACS_IDLE;
              d.busy   = 1'b0;    // R14
              d.eoc    = 1'b1;    // R4 R9
              d.result = d.dac;   // R4
              d.istat  = 1'b1;    // set beats clear
            end else begin
              d.cnt            = q.cnt - 4'h1;
              d.dac[q.cnt - 4'h1] = 1'b1;
            end
          end
        end
      end
      default: begin
        d.st = ACS_IDLE;
      end
    endcase

    // power-down aborts a conversion without an end flag
    if (!d.en && q.busy) begin  // R17
      d.st   = ACS_IDLE;
      d.busy = 1'b0;
    end

    // analog routing follows the held channel while busy
    d.rsel = d.busy ? d.l_sel : d.sel;                  // R1 R15
    d.conn = d.en && d.gen && (d.rsel <= ACS_LAST_CH);  // R5
    d.trt  = d.conn && (d.rsel == ACS_TEMP_CH);         // R16
    d.smp  = d.conn && (d.st == ACS_SAMPLE);
    d.irq  = d.istat & d.imask;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q      <= '0;
      q.sel  <= ACS_SEL_RST;
      q.div  <= ACS_DIV_RST;
      q.st   <= ACS_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o    = q.rdat;
  assign wb_ack_o    = q.ack;
  assign adc_power   = q.en;
  assign ain_connect = q.conn;
  assign ain_sel     = q.rsel;
  assign temp_route  = q.trt;
  assign ref_ext_sel = q.refx;
  assign sample_hold = q.smp;
  assign dac_code    = q.dac;
  assign irq         = q.irq;

  // assertion helper: conversion clocks seen in one conversion
  logic [6:0] nt_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n || start) begin
      nt_q <= 7'h00;
    end else if (q.busy && tick) begin
      nt_q <= nt_q + 7'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_start;
    start |=> q.busy && !q.eoc && (q.st == ACS_SAMPLE);
  endproperty
  a_start: assert property (p_start)  // R3
    else $error("accepted start did not begin a conversion");

  property p_eoc_clr;
    go |=> !q.eoc;
  endproperty
  a_eoc_clr: assert property (p_eoc_clr)  // R14
    else $error("end flag survived a start");

  property p_done;
    $fell(q.busy) && q.en |-> q.eoc && q.istat && (q.result == q.dac);
  endproperty
  a_done: assert property (p_done)  // R4
    else $error("conversion end without flag or result");

  property p_conn;
    ain_connect |-> adc_power && q.gen && (ain_sel <= ACS_LAST_CH);
  endproperty
  a_conn: assert property (p_conn)  // R5
    else $error("input connected without enables");

  property p_ref;
    wr && (adr_w == ACS_CTRL_OFS) && wb_sel_i[0]
      |=> ##1 ref_ext_sel == $past(wb_dat_i[ACS_B_REF], 2);
  endproperty
  a_ref: assert property (p_ref)  // R6
    else $error("reference select not taken from write");

  property p_len;
    $fell(q.busy) && q.eoc
      |-> nt_q == (q.l_res ? ACS_TICKS_12 : ACS_TICKS_8);
  endproperty
  a_len: assert property (p_len)  // R8
    else $error("conversion took the wrong number of steps");

  property p_div0;
    q.busy && (q.l_div == 3'h0) |-> tick;
  endproperty
  a_div0: assert property (p_div0)  // R10
    else $error("undivided clock missed a period");

  property p_hold;
    go && q.busy |=> q.busy && $stable(q.l_sel) && $stable(q.l_res);
  endproperty
  a_hold: assert property (p_hold)  // R18
    else $error("start during conversion disturbed it");

  property p_8bit;
    $rose(q.eoc) && !q.l_res |-> q.result[11:8] == 4'h0;
  endproperty
  a_8bit: assert property (p_8bit)  // R7
    else $error("8-bit result has upper bits set");

  property p_temp;
    temp_route |-> ain_connect && (ain_sel == ACS_TEMP_CH);
  endproperty
  a_temp: assert property (p_temp)  // R16
    else $error("temperature routed on wrong channel");

  c_done8:  cover property ($rose(q.eoc) && !q.l_res);
  c_done12: cover property ($rose(q.eoc) && q.l_res);
  c_ignore: cover property (go && q.busy);
  c_irq:    cover property ($rose(irq));

endmodule

//--- core/acs_pkg.sv
// package: register map, field positions and timing for the sequencer
package acs_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] ACS_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ACS_STAT_OFS  = 8'h04;
  localparam logic [7:0] ACS_DATA_OFS  = 8'h08;
  localparam logic [7:0] ACS_ISTAT_OFS = 8'h0C;
  localparam logic [7:0] ACS_IMASK_OFS = 8'h10;

  // control register field positions
  localparam int ACS_B_EN    = 0;   // converter_enable
  localparam int ACS_B_GEN   = 1;   // global_input_enable
  localparam int ACS_B_START = 2;   // conversion_start
  localparam int ACS_B_REF   = 3;   // high_reference_select
  localparam int ACS_B_RES   = 4;   // resolution_select
  localparam int ACS_B_SEL   = 8;   // input_select, 4 bits
  localparam int ACS_B_DIV   = 16;  // conversion_clock_divider, 3 bits

  // status register field positions
  localparam int ACS_B_EOC   = 0;
  localparam int ACS_B_BUSY  = 1;

  // reset values
  localparam logic [3:0] ACS_SEL_RST = 4'h0;
  localparam logic [2:0] ACS_DIV_RST = 3'h0;

  // channel plan: 14 pins plus the on-chip temperature channel
  localparam logic [3:0] ACS_LAST_CH = 4'hE;
  localparam logic [3:0] ACS_TEMP_CH = 4'hE;

  // largest divider code (divide by 32)
  localparam logic [2:0] ACS_DIV_MAX = 3'h5;

  // conversion timing in conversion-clock periods
  localparam logic [1:0] ACS_TICK_LAST  = 2'h3;  // 4 periods a step
  localparam logic [3:0] ACS_SAMP_LAST  = 4'h3;  // 4 sampling steps
  localparam logic [3:0] ACS_MSB_12     = 4'hB;  // 12-bit: 16 steps
  localparam logic [3:0] ACS_MSB_8      = 4'h7;  // 8-bit: 12 steps
  localparam logic [6:0] ACS_TICKS_12   = 7'h40; // 16 steps x 4
  localparam logic [6:0] ACS_TICKS_8    = 7'h30; // 12 steps x 4

  // sequencer states
  typedef enum logic [1:0] {
    ACS_IDLE   = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_BITS   = 2'b10
  } acs_state_e_t;

endpackage

//--- core/acs_clkdiv.sv
// conversion clock tick generator: divides core_clk by 1..32
`timescale 1ns/1ps
module acs_clkdiv
  import acs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic [2:0] div_sel,
  output logic            tick
);

  logic [4:0] cnt_q;  // cycles within one divided period
  logic [4:0] cnt_d;
  logic [4:0] lim;    // last count of the period
  logic [2:0] code;   // code clamped to divide by 32

  // reserved codes above divide-by-32 behave as divide-by-32
  assign code = (div_sel > ACS_DIV_MAX) ? ACS_DIV_MAX : div_sel;
  assign lim  = 5'((6'h01 << code) - 6'h01);
  assign tick = (cnt_q == lim);

  // restart on clear so every conversion has a fixed length
  always_comb begin
    if (clear || tick) begin
      cnt_d = 5'h00;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  // counter register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- sim/acs_afe_model.sv
// analog front model: per-channel levels and an async comparator
`timescale 1ns/1ps
module acs_afe_model
  import acs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic [14:0][11:0] lvl,
  input  wire logic             ain_connect,
  input  wire logic [3:0]       ain_sel,
  input  wire logic [11:0]      dac_code,
  output logic                  cmp_above
);
  logic flip_q = 1'b0;  // junk pattern while nothing is routed

  // free-running toggle so an open input never reads steady
  always @(posedge core_clk) begin
    flip_q <= ~flip_q;
  end

  // comparator sees the selected level only while the switch is closed
  always_comb begin
    if (ain_connect && ain_sel <= ACS_LAST_CH) begin
      cmp_above = (lvl[ain_sel] >= dac_code);
    end else begin
      cmp_above = flip_q;
    end
  end
endmodule

//--- sim/acs_core_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module acs_core_tb import acs_pkg::*; ;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, cmp_above, adc_power, ain_connect, temp_route;
  logic        ref_ext_sel, sample_hold, irq;
  logic [3:0]  ain_sel;
  logic [11:0] dac_code;
  logic [14:0][11:0] lvl = '0;           // channel levels seen by the model
  logic [31:0] seed = 32'h9152269F;      // xorshift state
  logic [31:0] rd;                       // last read data
  int          failures = 0;
  int          n_compared = 0;

  // 10 MHz, below the converter clock ceiling
  always #50 core_clk = ~core_clk;

  acs_core DUT (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_above,
    .adc_power, .ain_connect, .ain_sel, .temp_route, .ref_ext_sel,
    .sample_hold, .dac_code, .irq);

  acs_afe_model afe (.core_clk, .lvl, .ain_connect, .ain_sel, .dac_code,
    .cmp_above);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected successive-approximation code for a level
  function automatic logic [11:0] sar(input logic [11:0] v, input int msb);
    logic [11:0] c;
    c = '0;
    for (int b = msb; b >= 0; b--) begin
      if (v >= (c | (12'h1 << b))) begin
        c = c | (12'h1 << b);
      end
    end
    return c;
  endfunction

  // control word with the converter powered
  function automatic logic [31:0] ctl(input logic g, input logic st,
    input logic rf, input logic rs, input logic [3:0] ch,
    input logic [2:0] dv);
    logic [31:0] c;
    c = '0;
    c[ACS_B_EN] = 1'b1;
    c[ACS_B_GEN] = g;
    c[ACS_B_START] = st;
    c[ACS_B_REF] = rf;
    c[ACS_B_RES] = rs;
    c[ACS_B_SEL +: 4] = ch;
    c[ACS_B_DIV +: 3] = dv;
    return c;
  endfunction

  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // cycle counts checked against a window
  task automatic chk_rng(input string nm, input int lo, input int hi,
    input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      failures++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s = 4'hF);
    int k;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      failures++;
      end_sim();
    end
  endtask

  // poll status until end of conversion, bounded
  task automatic wait_eoc();
    int k;
    k = 0;
    do begin
      wb(1'b0, ACS_STAT_OFS, 32'h0);
      k++;
    end while (rd[ACS_B_EOC] !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      failures++;
      end_sim();
    end
  endtask

  initial begin
    logic [7:0] ofs [6];
    logic [3:0] ch;
    logic [11:0] v;
    logic [31:0] c;
    logic        rs;
    logic [2:0]  dv;
    realtime t0;
    int n, tk;
    ofs = '{ACS_CTRL_OFS, ACS_STAT_OFS, ACS_DATA_OFS, ACS_ISTAT_OFS,
      ACS_IMASK_OFS, 8'h14};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, unmapped place included
    foreach (ofs[i]) begin
      wb(1'b0, ofs[i], 32'h0);
      chk("reset read", 32'h0, rd);
    end
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // power up without the global enable: switch stays open
    wb(1'b1, ACS_IMASK_OFS, 32'h1);
    wb(1'b1, ACS_CTRL_OFS, ctl(1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 3'h0));
    repeat (2) @(posedge core_clk);
    chk("power", 32'h1, {31'h0, adc_power});
    chk("open", 32'h0, {31'h0, ain_connect});
    repeat (1000) @(posedge core_clk);
    // every select code, reference bit alternating
    for (int i = 0; i < 16; i++) begin
      ch = i[3:0];
      wb(1'b1, ACS_CTRL_OFS, ctl(1'b1, 1'b0, ch[0], 1'b0, ch, 3'h0));
      repeat (2) @(posedge core_clk);
      chk("sel", {28'h0, ch}, {28'h0, ain_sel});
      chk("conn", {31'h0, ch <= ACS_LAST_CH}, {31'h0, ain_connect});
      chk("temp", {31'h0, ch == ACS_TEMP_CH}, {31'h0, temp_route});
      chk("ref", {31'h0, ch[0]}, {31'h0, ref_ext_sel});
    end
    // lane 1 alone changes only the select field
    wb(1'b1, ACS_CTRL_OFS, 32'h0000_0500, 4'h2);
    wb(1'b0, ACS_CTRL_OFS, 32'h0);
    chk("lanes", ctl(1'b1, 1'b0, 1'b1, 1'b0, 4'h5, 3'h0), rd);
    $display("test routing done");
    // conversions over every divider code and both resolutions
    for (int i = 0; i < 16; i++) begin
      ch = 4'(rnd() % 15);
      v = 12'(rnd());
      if (i == 0) v = 12'h000;
      if (i == 5 || i == 11) v = 12'hFFF;
      rs = (i >= 8);
      dv = 3'(i % 8);
      lvl[ch] <= v;
      c = ctl(1'b1, 1'b1, 1'(rnd()), rs, ch, dv);
      wb(1'b1, ACS_CTRL_OFS, c);
      t0 = $realtime;
      wb(1'b0, ACS_STAT_OFS, 32'h0);
      chk("busy", 32'h2, rd);
      chk("sampling", 32'h1, {31'h0, sample_hold});
      chk("trial", 32'h0, {20'h0, dac_code});
      wb(1'b1, ACS_CTRL_OFS, c);
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 5000) begin
        failures++;
        end_sim();
      end
      n = int'(($realtime - t0) / 100.0);
      // codes above divide-by-32 behave as divide-by-32
      tk = (rs ? 64 : 48) << (dv > ACS_DIV_MAX ? ACS_DIV_MAX : dv);
      chk_rng("time", tk - 2, tk + 4, n);
      chk("hold off", 32'h0, {31'h0, sample_hold});
      chk("dac", {20'h0, sar(v, rs ? 11 : 7)}, {20'h0, dac_code});
      wb(1'b0, ACS_DATA_OFS, 32'h0);
      chk("result", {20'h0, sar(v, rs ? 11 : 7)}, rd);
      wb(1'b0, ACS_STAT_OFS, 32'h0);
      chk("eoc", 32'h1, rd);
      wb(1'b0, ACS_CTRL_OFS, 32'h0);
      c[ACS_B_START] = 1'b0;
      chk("ctrl", c, rd);
      wb(1'b1, ACS_ISTAT_OFS, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq clr", 32'h0, {31'h0, irq});
    end
    $display("test convert done");
    // masked event: flag sticks, line stays low until unmasked
    wb(1'b1, ACS_IMASK_OFS, 32'h0);
    wb(1'b1, ACS_CTRL_OFS, ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'hE, 3'h0));
    wait_eoc();
    wb(1'b0, ACS_ISTAT_OFS, 32'h0);
    chk("istat", 32'h1, rd);
    chk("masked", 32'h0, {31'h0, irq});
    wb(1'b1, ACS_IMASK_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("unmask", 32'h1, {31'h0, irq});
    wb(1'b1, ACS_ISTAT_OFS, 32'h1);
    // new start clears eoc, then power off aborts with no event
    wb(1'b1, ACS_CTRL_OFS, ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h2, 3'h2));
    wb(1'b0, ACS_STAT_OFS, 32'h0);
    chk("eoc clr", 32'h2, rd);
    wb(1'b1, ACS_CTRL_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("off", 32'h0, {31'h0, adc_power});
    repeat (400) @(posedge core_clk);
    wb(1'b0, ACS_STAT_OFS, 32'h0);
    chk("abort", 32'h0, rd);
    chk("no irq", 32'h0, {31'h0, irq});
    $display("test abort done");
    end_sim();
  end
endmodule
